// [inc/tone_pkg.sv]
// Constants for the musical tone generator.
// Assumes a machine cycle of CLK_PER_CYC (80) clocks; the state counts are in machine cycles.
package tone_pkg;
  localparam int     FIXED_CYC   = 100;
  localparam int     TIMER_BASE  = 9;
  localparam int     W1          = 3;
  localparam int     W2          = 4;
  localparam int     W3          = 5;
  localparam int     FILLER_CYC  = 89;
  localparam int     TEMPO_DIV   = 60;
  localparam int     SPACE_CYC   = 256;
  localparam int     CYCLE_NS    = 4000;
  localparam int     CLK_NS      = 50;
  localparam int     CLK_PER_CYC = CYCLE_NS / CLK_NS;
  localparam logic [3:0] LEN_LAST = 4'hF;
  localparam logic [7:0] STATUS_RST = 8'h00;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FIXED = 3'b001,
    ST_VAR   = 3'b011,
    ST_FILL  = 3'b010,
    ST_SPACE = 3'b110
  } tone_state_t;
endpackage : tone_pkg

// [core/tone_down_counter.sv]
// Loadable down counter with a terminal flag.
// Assumes synchronous load and a step enable.
`timescale 1ns/1ps
`default_nettype none
module tone_down_counter #(
  parameter int W = 10
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         load,
  input  wire logic [W-1:0] loadVal,
  input  wire logic         step,
  output logic              atOne
);
  logic [W-1:0] count_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_r <= '0;
    end else if (load) begin
      count_r <= loadVal;
    end else if (step && count_r != '0) begin
      count_r <= count_r - 1'b1;
    end
  end
  assign atOne = (count_r == {{(W-1){1'b0}}, 1'b1});
endmodule : tone_down_counter
`default_nettype wire

// [core/tone_tempo_div.sv]
// Tempo divider: synchronises tempo input, counts rising edges by 60.
// Assumes the tempo input is far slower than the machine cycle.
`timescale 1ns/1ps
`default_nettype none
module tone_tempo_div (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic tempoIn,
  input  wire logic clearFlag,
  output logic      secondsFlag
);
  logic       sync1_r;
  logic       sync2_r;
  logic       prev_r;
  logic [5:0] divCnt_r;
  logic       tick;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end else begin
      sync1_r <= tempoIn;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end
  assign tick = sync2_r & ~prev_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      divCnt_r <= 6'h00;
    end else if (tick) begin
      divCnt_r <= (divCnt_r == 6'(tone_pkg::TEMPO_DIV - 1)) ? 6'h00 : divCnt_r + 6'h01;
    end
  end
  // Set wins over clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      secondsFlag <= 1'b0;
    end else if (tick && divCnt_r == 6'(tone_pkg::TEMPO_DIV - 1)) begin
      secondsFlag <= 1'b1;
    end else if (clearFlag) begin
      secondsFlag <= 1'b0;
    end
  end
endmodule : tone_tempo_div
`default_nettype wire

// [core/musical_tone_generator.sv]
// Musical tone generator: half-period timing, octave repeat, outputs, length.
// Assumes codes held stable from start until done.
`timescale 1ns/1ps
`default_nettype none
module musical_tone_generator #(
  parameter int CLK_PER_CYC = tone_pkg::CLK_PER_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic [3:0] noteCode1,
  input  wire logic [3:0] noteCode2,
  input  wire logic [3:0] noteCode3,
  input  wire logic [3:0] octaveCode,
  input  wire logic [3:0] lengthCode,
  input  wire logic       restNote,
  input  wire logic       tempo_clock_in,
  output logic            busy,
  output logic            done,
  output logic            tone_out_octave1,
  output logic            tone_out_octave2,
  output logic            tone_out_octave3,
  output logic            tone_out_octave4,
  output logic            tone_out_octave1_inv,
  output logic            tone_out_octave2_inv,
  output logic            tone_out_octave3_inv,
  output logic            tone_out_octave4_inv,
  output logic            envelope_key_out,
  output logic            envelope_key_out_inv
);
  // ****************************************
  // Machine cycle strobe
  // ****************************************
  logic [7:0] preCnt_r;
  logic       mc;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      preCnt_r <= 8'h00;
    end else begin
      preCnt_r <= (preCnt_r == 8'(CLK_PER_CYC - 1)) ? 8'h00 : preCnt_r + 8'h01;
    end
  end
  assign mc = (preCnt_r == 8'(CLK_PER_CYC - 1));

  // ****************************************
  // Sequencer
  // ****************************************
  tone_pkg::tone_state_t state_r;
  logic [9:0]  cnt_r;
  logic [9:0]  varLen;
  logic [3:0]  repeat_r;
  logic [4:0]  lenCnt_r;
  logic [7:0]  status_r;
  logic        keyOn_r;
  logic        done_r;
  logic        secondsFlag;
  logic        seenFlag;
  logic        varLoad;
  logic        varEnd;

  assign varLen = 10'(tone_pkg::TIMER_BASE)
                + 10'(tone_pkg::W1) * 10'(4'hF - noteCode1)
                + 10'(tone_pkg::W2) * 10'(4'hF - noteCode2)
                + 10'(tone_pkg::W3) * 10'(4'hF - noteCode3);
  assign varLoad = (state_r != tone_pkg::ST_VAR) && mc
                 && ((state_r == tone_pkg::ST_FIXED && cnt_r == 10'h001)
                  || (state_r == tone_pkg::ST_FILL && cnt_r == 10'h001));

  tone_down_counter #(.W(10)) u_varTimer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .load    (varLoad),
    .loadVal (varLen),
    .step    (mc),
    .atOne   (varEnd)
  );

  tone_tempo_div u_tempo (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .tempoIn     (tempo_clock_in),
    .clearFlag   (seenFlag),
    .secondsFlag (secondsFlag)
  );

  // Half-period end: last variable part finished, no octave repeats left
  logic halfEnd;
  assign halfEnd  = mc && state_r == tone_pkg::ST_VAR && varEnd && repeat_r == 4'h0;
  assign seenFlag = halfEnd && secondsFlag;

  logic noteOver;
  assign noteOver = seenFlag && lenCnt_r == {1'b0, tone_pkg::LEN_LAST};

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= tone_pkg::ST_IDLE;
      cnt_r   <= 10'h000;
    end else begin
      case (state_r)
        tone_pkg::ST_IDLE: begin
          if (start) begin
            state_r <= tone_pkg::ST_FIXED;
            cnt_r   <= 10'(tone_pkg::FIXED_CYC);
          end
        end
        tone_pkg::ST_FIXED: begin
          if (mc) begin
            cnt_r <= cnt_r - 10'h001;
            if (cnt_r == 10'h001) begin
              state_r <= tone_pkg::ST_VAR;
            end
          end
        end
        tone_pkg::ST_VAR: begin
          if (mc && varEnd) begin
            if (repeat_r != 4'h0) begin
              state_r <= tone_pkg::ST_FILL;
              cnt_r   <= 10'(tone_pkg::FILLER_CYC);
            end else if (noteOver) begin
              state_r <= tone_pkg::ST_SPACE;
              cnt_r   <= 10'(tone_pkg::SPACE_CYC);
            end else begin
              state_r <= tone_pkg::ST_FIXED;
              cnt_r   <= 10'(tone_pkg::FIXED_CYC);
            end
          end
        end
        tone_pkg::ST_FILL: begin
          if (mc) begin
            cnt_r <= cnt_r - 10'h001;
            if (cnt_r == 10'h001) begin
              state_r <= tone_pkg::ST_VAR;
            end
          end
        end
        tone_pkg::ST_SPACE: begin
          if (mc) begin
            cnt_r <= cnt_r - 10'h001;
            if (cnt_r == 10'h001) begin
              state_r <= tone_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          state_r <= tone_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Octave repeat count
  // ****************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      repeat_r <= 4'h0;
    end else if (state_r == tone_pkg::ST_FIXED && mc && cnt_r == 10'(tone_pkg::FIXED_CYC)) begin
      repeat_r <= octaveCode;
    end else if (mc && state_r == tone_pkg::ST_VAR && varEnd && repeat_r != 4'h0) begin
      repeat_r <= repeat_r - 4'h1;
    end
  end

  // ****************************************
  // Output status and note length
  // ****************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status_r <= tone_pkg::STATUS_RST;
    end else if (halfEnd && !restNote) begin
      status_r <= status_r + 8'h01;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lenCnt_r <= 5'h00;
    end else if (state_r == tone_pkg::ST_IDLE && start) begin
      lenCnt_r <= {1'b0, lengthCode};
    end else if (seenFlag) begin
      lenCnt_r <= lenCnt_r + 5'h01;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      keyOn_r <= 1'b0;
    end else if (state_r == tone_pkg::ST_IDLE && start) begin
      keyOn_r <= 1'b1;
    end else if (mc && state_r == tone_pkg::ST_VAR && varEnd && repeat_r == 4'h0 && noteOver) begin
      keyOn_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      done_r <= 1'b0;
    end else begin
      done_r <= state_r == tone_pkg::ST_SPACE && mc && cnt_r == 10'h001;
    end
  end

  assign busy                 = state_r != tone_pkg::ST_IDLE;
  assign done                 = done_r;
  assign tone_out_octave1     = status_r[0];
  assign tone_out_octave2     = status_r[1];
  assign tone_out_octave3     = status_r[2];
  assign tone_out_octave4     = status_r[3];
  assign tone_out_octave1_inv = ~status_r[0];
  assign tone_out_octave2_inv = ~status_r[1];
  assign tone_out_octave3_inv = ~status_r[2];
  assign tone_out_octave4_inv = ~status_r[3];
  assign envelope_key_out     = keyOn_r;
  assign envelope_key_out_inv = ~keyOn_r;

  // ****************************************
  // Assertion helpers
  // ****************************************
  logic [15:0] halfMc_r;
  logic [9:0]  varMc_r;
  // Machine cycles since the half period began
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      halfMc_r <= 16'h0000;
    end else if (halfEnd) begin
      halfMc_r <= 16'h0000;
    end else if (mc && state_r != tone_pkg::ST_IDLE && state_r != tone_pkg::ST_SPACE) begin
      halfMc_r <= halfMc_r + 16'h0001;
    end
  end
  // Machine cycles in the current timer run
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      varMc_r <= 10'h000;
    end else if (mc && state_r == tone_pkg::ST_VAR) begin
      varMc_r <= varEnd ? 10'h000 : varMc_r + 10'h001;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_fixed_len: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(state_r == tone_pkg::ST_FIXED) |-> cnt_r == 10'(tone_pkg::FIXED_CYC))
    else $error("fixed part not 100 cycles");
  a_filler_len: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(state_r == tone_pkg::ST_FILL) |-> cnt_r == 10'(tone_pkg::FILLER_CYC))
    else $error("filler not 89 cycles");
  a_status_step: assert property (@(posedge ref_clk) disable iff (rst)
    halfEnd && !restNote |=> status_r == $past(status_r) + 8'h01)
    else $error("status did not increment");
  a_rest_hold: assert property (@(posedge ref_clk) disable iff (rst)
    halfEnd && restNote |=> $stable(status_r))
    else $error("rest changed outputs");
  a_inv_pair: assert property (@(posedge ref_clk) disable iff (rst)
    tone_out_octave1 != tone_out_octave1_inv && tone_out_octave4 != tone_out_octave4_inv)
    else $error("inverted outputs wrong");
  a_key_inv: assert property (@(posedge ref_clk) disable iff (rst)
    envelope_key_out != envelope_key_out_inv)
    else $error("key outputs not inverse");
  a_repeat_dec: assert property (@(posedge ref_clk) disable iff (rst)
    mc && state_r == tone_pkg::ST_VAR && varEnd && repeat_r != 4'h0
    |=> repeat_r == $past(repeat_r) - 4'h1)
    else $error("repeat not decremented");
  a_key_space: assert property (@(posedge ref_clk) disable iff (rst)
    state_r == tone_pkg::ST_SPACE |-> !envelope_key_out)
    else $error("key on during space");
  a_len_step: assert property (@(posedge ref_clk) disable iff (rst)
    seenFlag && !noteOver |=> lenCnt_r == $past(lenCnt_r) + 5'h01)
    else $error("length not advanced");
  a_half_total: assert property (@(posedge ref_clk) disable iff (rst)
    halfEnd |-> int'(halfMc_r) + 1 == tone_pkg::FIXED_CYC
      + (tone_pkg::TIMER_BASE + tone_pkg::W1 * (15 - int'(noteCode1))
      + tone_pkg::W2 * (15 - int'(noteCode2)) + tone_pkg::W3 * (15 - int'(noteCode3)))
      * (int'(octaveCode) + 1) + tone_pkg::FILLER_CYC * int'(octaveCode))
    else $error("half period length wrong");
  a_var_len: assert property (@(posedge ref_clk) disable iff (rst)
    mc && state_r == tone_pkg::ST_VAR && varEnd |-> int'(varMc_r) + 1
      == tone_pkg::TIMER_BASE
      + tone_pkg::W1 * (15 - int'(noteCode1)) + tone_pkg::W2 * (15 - int'(noteCode2))
      + tone_pkg::W3 * (15 - int'(noteCode3)))
    else $error("note period timer length wrong");
  a_oct_load: assert property (@(posedge ref_clk) disable iff (rst)
    state_r == tone_pkg::ST_FIXED && mc && cnt_r == 10'(tone_pkg::FIXED_CYC)
    |=> repeat_r == $past(octaveCode))
    else $error("octave code not copied");
  a_key_start: assert property (@(posedge ref_clk) disable iff (rst)
    state_r == tone_pkg::ST_IDLE && start |=> envelope_key_out && busy)
    else $error("note start not keyed");
  a_key_note: assert property (@(posedge ref_clk) disable iff (rst)
    state_r == tone_pkg::ST_FIXED || state_r == tone_pkg::ST_VAR
    || state_r == tone_pkg::ST_FILL |-> envelope_key_out)
    else $error("key off during note");
  a_note_end: assert property (@(posedge ref_clk) disable iff (rst)
    noteOver |=> state_r == tone_pkg::ST_SPACE && !envelope_key_out)
    else $error("note did not end");
  a_space_len: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(state_r == tone_pkg::ST_SPACE) |-> cnt_r == 10'(tone_pkg::SPACE_CYC))
    else $error("space length wrong");
  a_low_toggle: assert property (@(posedge ref_clk) disable iff (rst)
    halfEnd && !restNote |=> tone_out_octave1 != $past(tone_out_octave1))
    else $error("lowest pair did not toggle");
  a_done_pulse: assert property (@(posedge ref_clk) disable iff (rst)
    done |=> !done)
    else $error("done longer than one clock");
  c_fill: cover property (@(posedge ref_clk) state_r == tone_pkg::ST_FILL);
  c_space: cover property (@(posedge ref_clk) state_r == tone_pkg::ST_SPACE);
  c_done: cover property (@(posedge ref_clk) done);
  c_rest: cover property (@(posedge ref_clk) halfEnd && restNote);
  c_refused: cover property (@(posedge ref_clk) busy && start);
endmodule : musical_tone_generator
`default_nettype wire

// [verif/tone_speaker_model.sv]
// Far-side model: speaker, mixing filter and envelope circuit.
// Assumes all eight tone outputs and both keys of one generator.
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Listener: half-period timing and phases
// ****************************************
module tone_speaker_model (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        tone1,
  input  wire logic        tone2,
  input  wire logic        tone3,
  input  wire logic        tone4,
  input  wire logic        tone1Inv,
  input  wire logic        tone2Inv,
  input  wire logic        tone3Inv,
  input  wire logic        tone4Inv,
  input  wire logic        keyOut,
  input  wire logic        keyOutInv,
  output logic      [15:0] halfCount,
  output logic      [15:0] lastHalf,
  output logic      [15:0] complErr
);
  logic [3:0]  prevTone_r;
  logic [15:0] sinceEdge_r;
  logic        seenEdge_r;
  logic [3:0]  tone;
  assign tone = {tone4, tone3, tone2, tone1};
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prevTone_r  <= 4'h0;
      sinceEdge_r <= 16'h0000;
      seenEdge_r  <= 1'b0;
      halfCount   <= 16'h0000;
      lastHalf    <= 16'h0000;
      complErr    <= 16'h0000;
    end else begin
      prevTone_r  <= tone;
      sinceEdge_r <= sinceEdge_r + 16'h0001;
      if (tone != prevTone_r) begin
        halfCount   <= halfCount + 16'h0001;
        sinceEdge_r <= 16'h0001;
        // Last edge of a note lands as the key drops
        if (seenEdge_r) lastHalf <= sinceEdge_r;
      end
      seenEdge_r <= keyOut && (seenEdge_r || (tone != prevTone_r));
      if ({tone4Inv, tone3Inv, tone2Inv, tone1Inv} !== ~tone || keyOutInv !== ~keyOut)
        complErr <= complErr + 16'h0001;
    end
  end
endmodule : tone_speaker_model
`default_nettype wire

// [verif/musical_tone_generator_tb_top.sv]
// Testbench: plays notes through the generator and checks timing.
// Assumes one machine cycle per clock (CLK_PER_CYC set to 1).
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samplesChecked++; if ((a) !== (b)) begin errCount++; \
  $display("[FAIL] %0t got %0h expected %0h", $time, (a), (b)); end end
// ****************************************
// Bench top
// ****************************************
module musical_tone_generator_tb_top;
  logic        ref_clk, rst, start, restNote, tempo;
  logic [3:0]  c1, c2, c3, oct, len;
  logic        busy, done, o1, o2, o3, o4, i1, i2, i3, i4, key, keyInv;
  logic [15:0] halfCount, lastHalf, complErr;
  int          errCount, samplesChecked, cycles, tCnt, rises;
  musical_tone_generator #(.CLK_PER_CYC(1)) DUT (.ref_clk(ref_clk), .rst(rst),
    .start(start), .noteCode1(c1), .noteCode2(c2), .noteCode3(c3), .octaveCode(oct),
    .lengthCode(len), .restNote(restNote), .tempo_clock_in(tempo), .busy(busy),
    .done(done), .tone_out_octave1(o1), .tone_out_octave2(o2), .tone_out_octave3(o3),
    .tone_out_octave4(o4), .tone_out_octave1_inv(i1), .tone_out_octave2_inv(i2),
    .tone_out_octave3_inv(i3), .tone_out_octave4_inv(i4), .envelope_key_out(key),
    .envelope_key_out_inv(keyInv));
  tone_speaker_model spk (.ref_clk(ref_clk), .rst(rst), .tone1(o1), .tone2(o2),
    .tone3(o3), .tone4(o4), .tone1Inv(i1), .tone2Inv(i2), .tone3Inv(i3), .tone4Inv(i4),
    .keyOut(key), .keyOutInv(keyInv), .halfCount(halfCount), .lastHalf(lastHalf),
    .complErr(complErr));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // Tempo square wave, 40 clocks a period
  always @(negedge ref_clk) begin
    tCnt++;
    if (tCnt == 20) begin
      tCnt = 0;
      tempo = ~tempo;
      if (tempo && key === 1'b1) rises++;
    end
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 90000) begin
      errCount++;
      giveVerdict();
    end
  end
  function automatic int halfOf(input int a, b, c, o);
    int v;
    v = 9 + 3 * (15 - a) + 4 * (15 - b) + 5 * (15 - c);
    return 100 + v * (o + 1) + 89 * o;
  endfunction : halfOf
  task automatic giveVerdict();
    $display("checks %0d errors %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : giveVerdict
  task automatic playNote(input logic [3:0] a, b, d, o, l, input logic r, extra);
    int n;
    int sp;
    int h;
    logic [15:0] hc0;
    h = halfOf(a, b, d, o);
    @(negedge ref_clk);
    {c1, c2, c3, oct, len, restNote} = {a, b, d, o, l, r};
    start = 1'b1;
    rises = 0;
    hc0 = halfCount;
    @(negedge ref_clk);
    start = 1'b0;
    `CHK(busy, 1'b1)
    `CHK(key, 1'b1)
    `CHK(keyInv, 1'b0)
    n = 0;
    while (key === 1'b1 && n < 30000) begin
      @(negedge ref_clk);
      n++;
      start = extra && n == 500;
    end
    sp = 0;
    while (done !== 1'b1 && sp < 400) begin
      @(negedge ref_clk);
      sp++;
    end
    `CHK(sp >= 255 && sp <= 260, 1'b1)
    `CHK(rises + 2 >= (15 - l) * 60 && rises <= (16 - l) * 60 + h / 40 + 3, 1'b1)
    `CHK(complErr, 16'h0000)
    `CHK({o4, o3, o2, o1}, halfCount[3:0])
    if (r) begin
      `CHK(halfCount, hc0)
    end else begin
      `CHK(lastHalf, 16'(h))
    end
    @(negedge ref_clk);
    `CHK(busy, 1'b0)
    if (extra) begin
      n = 0;
      repeat (300) begin
        @(negedge ref_clk);
        n += (done === 1'b1 || busy === 1'b1);
      end
      `CHK(n, 0)
    end
  endtask : playNote
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {rst, start, restNote, tempo, c1, c2, c3, oct, len} = {4'h8, 20'h00000};
    {errCount, samplesChecked, cycles, tCnt, rises} = {5{32'h0}};
    repeat (8) @(negedge ref_clk);
    `CHK({o4, o3, o2, o1, i4, i3, i2, i1}, 8'h0F)
    `CHK({busy, done, key, keyInv}, 4'h1)
    rst = 1'b0;
    playNote(4'hF, 4'hF, 4'hD, 4'h0, 4'hD, 1'b0, 1'b0);
    playNote(4'hC, 4'hE, 4'hB, 4'h1, 4'hE, 1'b0, 1'b0);
    playNote(4'hC, 4'hE, 4'hB, 4'h3, 4'hE, 1'b0, 1'b0);
    playNote(4'h5, 4'hE, 4'h8, 4'h7, 4'hE, 1'b0, 1'b0);
    playNote(4'hF, 4'hF, 4'hF, 4'hF, 4'hE, 1'b0, 1'b0);
    playNote(4'hF, 4'hF, 4'hD, 4'h0, 4'hF, 1'b1, 1'b1);
    giveVerdict();
  end
endmodule : musical_tone_generator_tb_top
`default_nettype wire
